/* File: hdl/ccpc_pkg.sv */
// ccpc_pkg: register map, field positions, reset values and states of the
// control channel partner config block. Assumes APB with 32-bit words.
package ccpc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] CCPC_IDX_CHAN_CFG = 8'h32;
  localparam logic [7:0] CCPC_IDX_FWD_CTL = 8'h33;
  localparam logic [7:0] CCPC_IDX_RSVD_34 = 8'h34;
  localparam logic [7:0] CCPC_IDX_PART_CAP = 8'h35;
  localparam logic [7:0] CCPC_IDX_RSVD_36 = 8'h36;
  localparam logic [7:0] CCPC_IDX_PART_ID = 8'h37;
  localparam logic [7:0] CCPC_IDX_RSVD_38 = 8'h38;
  // control_channel_config fields
  localparam int CCPC_BIT_PASS_ALL = 7;
  localparam int CCPC_BIT_PASS_MATCH = 6;
  localparam int CCPC_BIT_AUTO_ACK = 5;
  localparam int CCPC_BIT_PARITY_ON = 3;
  // forward_path_control fields
  localparam int CCPC_BIT_CRC_ON = 2;
  localparam int CCPC_GPIO_LSB = 0;
  // partner_capabilities fields
  localparam int CCPC_BIT_HOLD_CAP = 7;
  localparam int CCPC_BIT_SELFTEST = 5;
  localparam int CCPC_BIT_MULTI_PORT = 4;
  localparam int CCPC_PORT_LSB = 0;
  // partner_identity fields
  localparam int CCPC_ID_LSB = 1;
  localparam int CCPC_BIT_HOLD_ID = 0;
  // reset values
  localparam logic [7:0] CCPC_RST_CHAN_CFG = 8'h09;
  localparam logic [7:0] CCPC_RST_FWD_CTL = 8'h04;
  localparam logic [7:0] CCPC_RST_ZERO = 8'h00;
  localparam logic [6:0] CCPC_RST_PART_ID = 7'h2A; // arbitrary value
  // forward control sequence framing
  localparam logic [2:0] CCPC_SEQ_LAST = 3'h7;   // eighth protected byte
  localparam logic [7:0] CCPC_CRC_POLY = 8'h07;
  localparam logic [7:0] CCPC_CRC_INIT = 8'h00;
  typedef enum logic [1:0] {
    CCPC_ST_PASS = 2'b01,
    CCPC_ST_CRC = 2'b10
  } ccpc_seq_state_e;
endpackage

/* File: hdl/ccpc_crc_if.sv */
// ccpc_crc_if: carries CRC control and result between the block and its CRC
// engine. Single clock domain.
`timescale 1ns/10ps
interface ccpc_crc_if;
  logic clr;
  logic upd;
  logic [7:0] data;
  logic [7:0] crc;
  modport ctrl (output clr, output upd, output data, input crc);
  modport eng (input clr, input upd, input data, output crc);
endinterface

/* File: hdl/ccpc_crc8.sv */
// ccpc_crc8: byte-wise CRC-8 register for the forward control sequence.
// Assumes i_clk_sys, synchronous active-high reset.
`timescale 1ns/10ps
module ccpc_crc8 (
  input wire logic i_clk_sys, // system clock
  input wire logic i_reset,   // sync reset
  ccpc_crc_if.eng crc_bus     // control and result
);
  import ccpc_pkg::*;
  logic [7:0] crc_r;
  logic [7:0] crc_nxt;
  logic [7:0] seed;

  always_comb begin
    seed = crc_bus.clr ? CCPC_CRC_INIT : crc_r;
    crc_nxt = seed ^ crc_bus.data;
    for (int i = 0; i < 8; i++) begin
      crc_nxt = crc_nxt[7] ? ((crc_nxt << 1) ^ CCPC_CRC_POLY) : (crc_nxt << 1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      crc_r <= CCPC_CRC_INIT;
    end else if (crc_bus.upd) begin
      crc_r <= crc_nxt;
    end
  end

  assign crc_bus.crc = crc_r;
endmodule // ccpc_crc8

/* File: hdl/ccpc_top.sv */
// ccpc_top: control channel configuration and partner capability registers
// with the channel-side logic they steer.
// Assumes APB slave at i_clk_sys, all inputs synchronous to it.
// limitation: alias matching and the target table sit outside; only the chosen address comes in.
// back channel capability fields are taken on the link-up edge only, so a steady link never undoes a write.
// What this block does
// - with pass-all set, every local I2C transaction is forwarded; clear disables it.
// - with matched pass-through set and pass-all clear, a transaction is forwarded only on address match.
// - with auto-ack set, every I2C write is acked locally regardless of lock or remote ack.
// - the receive parity checker runs when enabled and is bypassed when not; resets enabled.
// - with CRC enable set, each forward control sequence carries a CRC; resets on.
// - the CRC covers the first eight sequence bytes and goes out as the ninth byte.
// - a two-bit field selects 0, 1, 2 or 4 forward GPIOs; resets to none.
// - with capability hold set, auto-loading stops and software values are kept.
// - the self-test flag shows that the partner requests link self-test.
// - self-test, multi-port and port number load automatically when the back channel is detected.
// - the multi-port bit reads 0 for a single-port and 1 for a multi-port partner.
// - a four-bit field holds the partner port number this serializer is attached to.
// - the seven-bit partner identity loads automatically from the back channel.
// - with identity hold set, identity auto-loading stops and the written value is kept.
// - a forwarded transaction to an alias gets the remote target address substituted.
`timescale 1ns/10ps
module ccpc_top (
  input wire logic i_clk_sys,            // 200 MHz system clock
  input wire logic i_reset,              // sync reset, active high
  // apb slave
  input wire logic i_psel,               // select
  input wire logic i_penable,            // access phase
  input wire logic i_pwrite,             // write
  input wire logic [11:0] i_paddr,       // byte address
  input wire logic [31:0] i_pwdata,      // write data
  output logic o_pready,                 // ready
  output logic [31:0] o_prdata,          // read data
  output logic o_pslverr,                // unmapped address
  // local i2c transaction
  input wire logic i_i2c_req,            // transaction start pulse
  input wire logic i_i2c_write,          // transaction is a write
  input wire logic [6:0] i_i2c_addr,     // target address
  input wire logic i_i2c_decode_hit,     // address decode matched
  input wire logic i_i2c_alias_hit,      // address is a configured alias
  input wire logic [6:0] i_remote_target_address, // remapped address
  input wire logic i_fwd_lock,           // forward link locked
  input wire logic i_remote_ack,         // ack from far side
  output logic o_fwd_valid,              // forward pulse
  output logic [6:0] o_fwd_addr,         // address sent across
  output logic o_i2c_ack,                // ack returned locally
  // receive path
  input wire logic i_rx_valid,           // received byte valid
  input wire logic [7:0] i_rx_data,      // received byte
  input wire logic i_rx_parity,          // received parity bit
  output logic o_rx_valid,               // accepted byte valid
  output logic [7:0] o_rx_data,          // accepted byte
  output logic o_rx_parity_err,          // parity error pulse
  // forward control sequence
  input wire logic i_seq_valid,          // sequence byte valid
  input wire logic i_seq_first,          // first byte of sequence
  input wire logic [7:0] i_seq_byte,     // sequence byte
  output logic o_seq_ready,              // accepting bytes
  output logic o_seq_valid,              // output byte valid
  output logic [7:0] o_seq_byte,         // output byte
  output logic [2:0] o_forward_gpio_count, // gpios carried
  // back channel
  input wire logic i_bc_link_up,         // back channel detected
  input wire logic i_bc_selftest,        // partner self-test request
  input wire logic i_bc_multi_port,      // partner is multi-port
  input wire logic [3:0] i_bc_port,      // partner port number
  input wire logic i_bc_id_valid,        // identity report pulse
  input wire logic [6:0] i_bc_id,        // reported identity
  output logic o_partner_selftest_request // partner asks for self-test
);
  import ccpc_pkg::*;

  logic [7:0] chan_cfg_r;
  logic [7:0] fwd_ctl_r;
  logic [7:0] rsvd_34_r;
  logic [7:0] part_cap_r;
  logic [7:0] rsvd_36_r;
  logic [7:0] part_id_r;
  logic [7:0] rsvd_38_r;
  logic link_up_r;
  logic [9:0] word_idx;
  logic mapped;
  logic wr_en;
  logic rd_en;
  logic [7:0] rd_val;
  logic setup_ph;
  logic bc_rise;
  logic cap_load;
  logic id_load;
  logic [2:0] gpio_cnt_nxt;
  logic seq_last;
  logic rx_ok;
  logic seq_take;
  logic [2:0] seq_cnt_r;
  ccpc_seq_state_e seq_state_r;
  ccpc_crc_if crc_bus ();

  ccpc_crc8 u_crc (
    .i_clk_sys (i_clk_sys),
    .i_reset (i_reset),
    .crc_bus (crc_bus)
  );

  // apb decode; one wait-free access phase, ready comes from a flop
  assign word_idx = i_paddr[11:2];
  assign wr_en = i_psel & i_penable & o_pready & i_pwrite & mapped;
  assign rd_en = i_psel & i_penable & o_pready & ~i_pwrite;
  assign setup_ph = i_psel & ~i_penable & ~o_pready;

  always_comb begin
    mapped = 1'b1;
    rd_val = 8'h00;
    case (word_idx)
      {2'b00, CCPC_IDX_CHAN_CFG}: rd_val = chan_cfg_r;
      {2'b00, CCPC_IDX_FWD_CTL}: rd_val = fwd_ctl_r;
      {2'b00, CCPC_IDX_RSVD_34}: rd_val = rsvd_34_r;
      {2'b00, CCPC_IDX_PART_CAP}: rd_val = part_cap_r;
      {2'b00, CCPC_IDX_RSVD_36}: rd_val = rsvd_36_r;
      {2'b00, CCPC_IDX_PART_ID}: rd_val = part_id_r;
      {2'b00, CCPC_IDX_RSVD_38}: rd_val = rsvd_38_r;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      // the ready term keeps a protocol slip from being answered twice
      o_pready <= setup_ph;
      o_pslverr <= setup_ph & ~mapped;
      if (i_psel & ~i_penable & ~i_pwrite) begin
        o_prdata <= {24'h00_0000, rd_val};
      end else if (rd_en) begin
        o_prdata <= o_prdata;
      end
    end
  end

  // plain configuration registers
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      chan_cfg_r <= CCPC_RST_CHAN_CFG;
      fwd_ctl_r <= CCPC_RST_FWD_CTL;
      rsvd_34_r <= CCPC_RST_ZERO;
      rsvd_36_r <= CCPC_RST_ZERO;
      rsvd_38_r <= CCPC_RST_ZERO;
    end else if (wr_en) begin
      case (word_idx)
        {2'b00, CCPC_IDX_CHAN_CFG}: chan_cfg_r <= i_pwdata[7:0];
        {2'b00, CCPC_IDX_FWD_CTL}: fwd_ctl_r <= i_pwdata[7:0];
        {2'b00, CCPC_IDX_RSVD_34}: rsvd_34_r <= i_pwdata[7:0];
        {2'b00, CCPC_IDX_RSVD_36}: rsvd_36_r <= i_pwdata[7:0];
        {2'b00, CCPC_IDX_RSVD_38}: rsvd_38_r <= i_pwdata[7:0];
        default: ;
      endcase
    end
  end

  // partner capabilities: load on back channel detection unless held
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      link_up_r <= 1'b0;
    end else begin
      link_up_r <= i_bc_link_up;
    end
  end

  // edge, not level: a link that stays up must not keep rewriting the fields
  assign bc_rise = i_bc_link_up & ~link_up_r;
  assign cap_load = bc_rise & ~part_cap_r[CCPC_BIT_HOLD_CAP];
  assign id_load = i_bc_id_valid & ~part_id_r[CCPC_BIT_HOLD_ID];

  // software write wins a same-cycle load so a write that also sets hold sticks
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      part_cap_r <= CCPC_RST_ZERO;
    end else if (wr_en && word_idx == {2'b00, CCPC_IDX_PART_CAP}) begin
      part_cap_r <= i_pwdata[7:0];
    end else if (cap_load) begin
      part_cap_r[CCPC_BIT_SELFTEST] <= i_bc_selftest;
      part_cap_r[CCPC_BIT_MULTI_PORT] <= i_bc_multi_port;
      part_cap_r[CCPC_PORT_LSB +: 4] <= i_bc_port;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      part_id_r <= {CCPC_RST_PART_ID, 1'b0};
    end else if (wr_en && word_idx == {2'b00, CCPC_IDX_PART_ID}) begin
      part_id_r <= i_pwdata[7:0];
    end else if (id_load) begin
      part_id_r[CCPC_ID_LSB +: 7] <= i_bc_id;
    end
  end

  // code 11 means four, not three, so a plain copy of the field would be wrong
  always_comb begin
    case (fwd_ctl_r[CCPC_GPIO_LSB +: 2])
      2'b00: gpio_cnt_nxt = 3'h0;
      2'b01: gpio_cnt_nxt = 3'h1;
      2'b10: gpio_cnt_nxt = 3'h2;
      default: gpio_cnt_nxt = 3'h4;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_partner_selftest_request <= 1'b0;
      o_forward_gpio_count <= 3'h0;
    end else begin
      o_partner_selftest_request <= part_cap_r[CCPC_BIT_SELFTEST];
      o_forward_gpio_count <= gpio_cnt_nxt;
    end
  end

  // i2c forwarding and local acknowledge
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_fwd_valid <= 1'b0;
      o_fwd_addr <= 7'h00;
      o_i2c_ack <= 1'b0;
    end else begin
      o_fwd_valid <= i_i2c_req & (chan_cfg_r[CCPC_BIT_PASS_ALL]
                     | (chan_cfg_r[CCPC_BIT_PASS_MATCH] & i_i2c_decode_hit));
      if (i_i2c_req) begin
        o_fwd_addr <= i_i2c_alias_hit ? i_remote_target_address : i_i2c_addr;
      end
      // auto-ack ignores lock and remote answer entirely
      o_i2c_ack <= (i_i2c_req & i_i2c_write & chan_cfg_r[CCPC_BIT_AUTO_ACK])
                   | (i_remote_ack & i_fwd_lock);
    end
  end

  // receive parity check, even parity; bypass passes every byte
  assign rx_ok = ~chan_cfg_r[CCPC_BIT_PARITY_ON] | ~(^{i_rx_data, i_rx_parity});

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
      o_rx_parity_err <= 1'b0;
    end else begin
      // a failing byte is dropped here; the consumer only sees the error pulse
      o_rx_valid <= i_rx_valid & rx_ok;
      o_rx_parity_err <= i_rx_valid & ~rx_ok;
      if (i_rx_valid) begin
        o_rx_data <= i_rx_data;
      end
    end
  end

  // forward control sequence with CRC slot after the eighth byte
  assign seq_take = i_seq_valid & o_seq_ready;
  assign crc_bus.clr = i_seq_first;
  assign crc_bus.upd = seq_take & (i_seq_first | seq_cnt_r != 3'h0) & (seq_state_r == CCPC_ST_PASS);
  assign crc_bus.data = i_seq_byte;
  // a new first byte always restarts, even where the eighth slot would fall
  assign seq_last = (seq_cnt_r == CCPC_SEQ_LAST) & ~i_seq_first;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      seq_state_r <= CCPC_ST_PASS;
      seq_cnt_r <= 3'h0;
      o_seq_ready <= 1'b1;
      o_seq_valid <= 1'b0;
      o_seq_byte <= 8'h00;
    end else begin
      o_seq_valid <= 1'b0;
      case (seq_state_r)
        CCPC_ST_PASS: begin
          if (seq_take) begin
            o_seq_valid <= 1'b1;
            o_seq_byte <= i_seq_byte;
            // count only inside a sequence; a stray byte past the eighth is passed unprotected
            if (i_seq_first) begin
              seq_cnt_r <= 3'h1;
            end else if (seq_cnt_r != 3'h0) begin
              seq_cnt_r <= seq_cnt_r + 3'h1;
            end
            if (seq_last && fwd_ctl_r[CCPC_BIT_CRC_ON]) begin
              seq_state_r <= CCPC_ST_CRC;
              o_seq_ready <= 1'b0;
            end
          end
        end
        CCPC_ST_CRC: begin
          // the crc byte takes a cycle of its own; input is stalled through it
          o_seq_valid <= 1'b1;
          o_seq_byte <= crc_bus.crc;
          seq_cnt_r <= 3'h0;
          o_seq_ready <= 1'b1;
          seq_state_r <= CCPC_ST_PASS;
        end
        default: begin
          seq_state_r <= CCPC_ST_PASS;
          o_seq_ready <= 1'b1;
        end
      endcase
    end
  end
endmodule // ccpc_top

/* File: tb/ccpc_checker.sv */
// ccpc_checker: port-level assertions for ccpc_top.
// Assumes a bind into ccpc_top, one clock, sync active-high reset.
`timescale 1ns/10ps
module ccpc_checker (
  input wire logic i_clk_sys, // clock
  input wire logic i_reset, // reset
  input wire logic i_psel, // select
  input wire logic i_penable, // access
  input wire logic o_pready, // ready
  input wire logic o_pslverr, // error
  input wire logic i_i2c_req, // i2c start
  input wire logic i_i2c_alias_hit, // alias
  input wire logic [6:0] i_i2c_addr, // address
  input wire logic [6:0] i_remote_target_address, // remap
  input wire logic o_fwd_valid, // forwarded
  input wire logic [6:0] o_fwd_addr, // sent address
  input wire logic i_rx_valid, // rx in
  input wire logic [7:0] i_rx_data, // rx byte
  input wire logic i_rx_parity, // rx parity
  input wire logic o_rx_valid, // rx out
  input wire logic [7:0] o_rx_data, // rx byte out
  input wire logic o_rx_parity_err, // parity error
  input wire logic i_seq_valid, // seq in
  input wire logic [7:0] i_seq_byte, // seq byte
  input wire logic o_seq_ready, // seq ready
  input wire logic o_seq_valid, // seq out
  input wire logic [7:0] o_seq_byte, // seq byte out
  input wire logic [2:0] o_forward_gpio_count // gpios
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  apb_answer_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  err_with_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  fwd_cause_a: assert property (o_fwd_valid |-> $past(i_i2c_req))
    else $error("forward without request");
  alias_remap_a: assert property (o_fwd_valid && $past(i_i2c_alias_hit) |->
    o_fwd_addr == $past(i_remote_target_address)) else $error("alias not remapped");
  direct_addr_a: assert property (o_fwd_valid && !$past(i_i2c_alias_hit) |->
    o_fwd_addr == $past(i_i2c_addr)) else $error("address altered");
  rx_answer_a: assert property (i_rx_valid |=> o_rx_valid != o_rx_parity_err)
    else $error("rx byte not answered once");
  parity_err_a: assert property (o_rx_parity_err |-> ^{$past(i_rx_data), $past(i_rx_parity)})
    else $error("parity error on good byte");
  rx_data_a: assert property (o_rx_valid |-> o_rx_data == $past(i_rx_data))
    else $error("rx data changed");
  seq_echo_a: assert property (i_seq_valid && o_seq_ready |=>
    o_seq_valid && o_seq_byte == $past(i_seq_byte)) else $error("seq byte not echoed");
  crc_slot_a: assert property ($fell(o_seq_ready) |=> o_seq_ready && o_seq_valid)
    else $error("crc byte slot wrong");
  gpio_legal_a: assert property (o_forward_gpio_count inside {3'h0, 3'h1, 3'h2, 3'h4})
    else $error("illegal gpio count");
endmodule // ccpc_checker

/* File: tb/ccpc_bc_partner.sv */
// ccpc_bc_partner: behavioural remote deserializer on the back channel.
// Assumes i_clk_sys; the bench calls its tasks.
`timescale 1ns/10ps
module ccpc_bc_partner (
  input wire logic i_clk_sys, // clock
  output logic o_link_up, // back channel up
  output logic o_selftest, // self-test request
  output logic o_multi_port, // multi-port partner
  output logic [3:0] o_port, // port number
  output logic o_id_valid, // identity pulse
  output logic [6:0] o_id // identity
);
  initial begin
    {o_link_up, o_selftest, o_multi_port, o_port, o_id_valid, o_id} = 15'h0;
  end
  // fields only mean something at the link-up edge, so scramble them after
  task automatic link(input logic st, input logic mp, input logic [3:0] pn);
    @(posedge i_clk_sys);
    o_link_up <= 1'b0;
    @(posedge i_clk_sys);
    o_link_up <= 1'b1;
    {o_selftest, o_multi_port, o_port} <= {st, mp, pn};
    @(posedge i_clk_sys);
    {o_selftest, o_multi_port, o_port} <= ~{st, mp, pn};
  endtask
  task automatic ident(input logic [6:0] id);
    @(posedge i_clk_sys);
    {o_id_valid, o_id} <= {1'b1, id};
    @(posedge i_clk_sys);
    {o_id_valid, o_id} <= {1'b0, ~id};
  endtask
endmodule // ccpc_bc_partner

/* File: tb/tb.sv */
// tb: register, i2c, rx, sequence and back channel tests of ccpc_top.
// Assumes the partner model drives the back channel inputs.
`timescale 1ns/10ps
module tb;
  import ccpc_pkg::*;
  logic i_clk_sys = 1'b0, i_reset = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic o_pready, o_pslverr, o_fwd_valid, o_i2c_ack, o_rx_valid, o_rx_parity_err, se;
  logic o_seq_ready, o_seq_valid, o_partner_selftest_request;
  logic [6:0] o_fwd_addr;
  logic [7:0] o_rx_data, o_seq_byte;
  logic [2:0] o_forward_gpio_count;
  logic i_i2c_req = 1'b0, i_i2c_write = 1'b0, i_i2c_decode_hit = 1'b0, i_i2c_alias_hit = 1'b0;
  logic i_fwd_lock = 1'b0, i_remote_ack = 1'b0, i_rx_valid = 1'b0, i_rx_parity = 1'b0;
  logic i_seq_valid = 1'b0, i_seq_first = 1'b0;
  logic [6:0] i_i2c_addr = 7'h12, i_remote_target_address = 7'h55;
  logic [7:0] i_rx_data = 8'h00, i_seq_byte = 8'h00;
  logic i_bc_link_up, i_bc_selftest, i_bc_multi_port, i_bc_id_valid;
  logic [3:0] i_bc_port;
  logic [6:0] i_bc_id;
  logic [7:0] sq[$];
  logic [7:0] db[8] = '{8'h01, 8'hFF, 8'h80, 8'h3C, 8'h00, 8'hA5, 8'h7E, 8'h42};
  logic [7:0] rst_tab[7] = '{8'h09, 8'h04, 8'h00, 8'h00, 8'h00, {CCPC_RST_PART_ID, 1'b0}, 8'h00};
  logic [7:0] rsv[3] = '{8'h34, 8'h36, 8'h38};
  logic [2:0] gp[4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  int error_cnt = 0, cmp_count = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) if (o_seq_valid) sq.push_back(o_seq_byte);
  ccpc_top ccpc_top_inst (.*);
  ccpc_bc_partner ccpc_bc_partner_inst (.i_clk_sys(i_clk_sys), .o_link_up(i_bc_link_up),
    .o_selftest(i_bc_selftest), .o_multi_port(i_bc_multi_port), .o_port(i_bc_port),
    .o_id_valid(i_bc_id_valid), .o_id(i_bc_id));
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n = 0;
    @(posedge i_clk_sys);
    {i_psel, i_penable, i_pwrite} <= {1'b1, 1'b0, wr};
    i_paddr <= {2'h0, idx, 2'h0};
    i_pwdata <= {24'h0, wd};
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      error_cnt++;
      summarize();
    end
    rd = o_prdata;
    se = o_pslverr;
    {i_psel, i_penable} <= 2'h0;
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  task automatic i2c(input logic wr, input logic dec, input logic al, input logic fw, input logic ak);
    @(posedge i_clk_sys);
    {i_i2c_req, i_i2c_write, i_i2c_decode_hit, i_i2c_alias_hit} <= {1'b1, wr, dec, al};
    @(posedge i_clk_sys);
    i_i2c_req <= 1'b0;
    #1 chk(o_fwd_valid, fw);
    chk(o_i2c_ack, ak);
  endtask
  task automatic rx(input logic [7:0] d, input logic p, input logic v, input logic e);
    @(posedge i_clk_sys);
    {i_rx_valid, i_rx_data, i_rx_parity} <= {1'b1, d, p};
    @(posedge i_clk_sys);
    {i_rx_valid, i_rx_data} <= {1'b0, ~d};
    #1 chk(o_rx_valid, v);
    chk(o_rx_parity_err, e);
  endtask
  // msb-first crc-8, poly 0x07, init 0
  function automatic logic [7:0] crc8();
    logic [7:0] c = 8'h00;
    foreach (db[k]) begin
      c ^= db[k];
      repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  task automatic seq(input int cnt);
    for (int k = 0; k < 8; k++) begin
      @(posedge i_clk_sys);
      {i_seq_valid, i_seq_first, i_seq_byte} <= {1'b1, k == 0, db[k]};
    end
    @(posedge i_clk_sys);
    {i_seq_valid, i_seq_byte} <= {1'b0, 8'h00};
    repeat (4) @(posedge i_clk_sys);
    chk(sq.size(), cnt);
    for (int k = 0; k < cnt; k++) chk(sq[k], k < 8 ? db[k] : crc8());
    sq.delete();
  endtask
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    foreach (rst_tab[k]) rc(8'(8'h32 + k), rst_tab[k]);
    apb(1'b1, 8'h3F, 8'hFF);
    rc(8'h3F, 8'h00);
    chk(se, 1'b1);
    foreach (rsv[k]) begin
      apb(1'b1, rsv[k], 8'hA5);
      rc(rsv[k], 8'hA5);
    end
    $display("register test done");
    foreach (gp[k]) begin
      apb(1'b1, 8'h33, 8'(k));
      @(posedge i_clk_sys);
      #1 chk(o_forward_gpio_count, gp[k]);
    end
    $display("gpio test done");
    i2c(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    apb(1'b1, 8'h32, 8'h59);
    rc(8'h32, 8'h59);
    i2c(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    i2c(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    apb(1'b1, 8'h32, 8'h89);
    i2c(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    apb(1'b1, 8'h32, 8'h29);
    i2c(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    i2c(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    apb(1'b1, 8'h32, 8'h09);
    {i_fwd_lock, i_remote_ack} <= 2'b11;
    i2c(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    {i_fwd_lock, i_remote_ack} <= 2'b01;
    i2c(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    i_remote_ack <= 1'b0;
    $display("i2c test done");
    rx(8'h5A, 1'b1, 1'b0, 1'b1);
    rx(8'h5B, 1'b1, 1'b1, 1'b0);
    apb(1'b1, 8'h32, 8'h01);
    rx(8'h5A, 1'b1, 1'b1, 1'b0);
    $display("parity test done");
    seq(8);
    apb(1'b1, 8'h33, 8'h04);
    seq(9);
    $display("sequence test done");
    ccpc_bc_partner_inst.link(1'b1, 1'b1, 4'h5);
    rc(8'h35, 8'h35);
    chk(o_partner_selftest_request, 1'b1);
    ccpc_bc_partner_inst.link(1'b0, 1'b0, 4'h9);
    rc(8'h35, 8'h09);
    chk(o_partner_selftest_request, 1'b0);
    apb(1'b1, 8'h35, 8'hA3);
    ccpc_bc_partner_inst.link(1'b0, 1'b1, 4'hC);
    rc(8'h35, 8'hA3);
    ccpc_bc_partner_inst.ident(7'h11);
    rc(8'h37, 8'h22);
    apb(1'b1, 8'h37, 8'h0B);
    ccpc_bc_partner_inst.ident(7'h11);
    rc(8'h37, 8'h0B);
    $display("back channel test done");
    summarize();
  end
endmodule // tb
bind ccpc_top ccpc_checker ccpc_checker_inst (.*);
